//--- src/cci_regs.svh
`ifndef CCI_REGS_SVH
`define CCI_REGS_SVH
// register byte offsets on the apb bus
`define CCI_CMPCTRL_OFF 12'h000
`define CCI_FLAGREG2_OFF 12'h004
`define CCI_ENREG2_OFF 12'h008
`define CCI_IRQCTRL_OFF 12'h00C
`define CCI_CONV1_OFF 12'h010
`define CCI_VREFCTRL_OFF 12'h014
`define CCI_IRQSTAT_OFF 12'h018
`define CCI_IRQMASK_OFF 12'h01C
// field positions
`define CCI_CMP2_OUTPUT_BIT 7
`define CCI_CMP1_OUTPUT_BIT 6
`define CCI_CFG_LSB 0
`define CCI_CHG_BIT 6
`define CCI_CMPIE_BIT 6
`define CCI_PERIPH_IRQ_ENABLE_BIT 6
`define CCI_GIE_BIT 7
`define CCI_VON_BIT 7
`define CCI_VOE_BIT 6
`define CCI_VRR_BIT 5
// reset values
`define CCI_CFG_RST 3'h7
`define CCI_PCFG_RST 4'h0
`define CCI_VREF_RST 8'h00
`endif

//--- src/cci_pkg.sv
package cci_pkg;
    // apb request bundle
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cci_apb_req_t;
    // sticky event bits in the system status register
    typedef struct packed {
        logic wake;
        logic change;
    } cci_evt_t;
endpackage

//--- src/comparator_change_irq.sv
`timescale 1ns/1ps
`include "cci_regs.svh"

// Contract
// - set change flag on any output change
// - comparator outputs readable at bits 7:6
// - flag sticks until software writes zero
// - writing one sets flag like change
// - interrupt needs all three enables set
// - flag still sets when interrupt disabled
// - change during control read may miss
// - control access refreshes reference copy
// - mismatch keeps setting flag
// - works in sleep, wakes when enabled
// - wake leaves control register unchanged
// - reset sets config field to 111
// - pins analog after reset, port field
// - reset clears vref control bits
// - wake leaves vref control unchanged
// - vref pin driven only when enabled
module comparator_change_irq (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp1Raw,
    input wire logic cmp2Raw,
    input wire logic sleepMode,
    output logic cmpIrqReq,
    output logic wakeReq,
    output logic [2:0] cmpConfigField,
    output logic [3:0] portAnalogConfig,
    output logic [7:0] vrefControl,
    output logic vrefOutPinEn,
    output logic sysIrq
);
    cci_pkg::cci_apb_req_t req; // bundled bus request
    logic acc; // access phase
    logic wr; // write access
    logic rd; // read setup cycle, loads the read data flop
    logic [1:0] s1_q, s1_d; // first sync stage
    logic [1:0] s2_q, s2_d; // second sync stage
    logic [1:0] ref_q, ref_d; // reference copy of outputs
    logic chg_q, chg_d; // change flag
    logic cmpIe_q, cmpIe_d; // local enable
    logic periph_irq_enable_q, periph_irq_enable_d; // peripheral enable
    logic gIe_q, gIe_d; // global enable
    logic [2:0] cfg_q, cfg_d; // comparator config
    logic [3:0] pcfg_q, pcfg_d; // port analog config
    logic [7:0] vref_q, vref_d; // vref control
    cci_pkg::cci_evt_t st_q, st_d; // sticky status
    cci_pkg::cci_evt_t msk_q, msk_d; // status mask
    logic [31:0] rdata_q, rdata_d; // read data
    logic mismatch; // live differs from copy
    logic ctrlAcc; // control register touched
    logic irqOn; // gated interrupt

    // pack bus inputs
    always_comb begin
        req.sel = psel;
        req.enable = penable;
        req.write = pwrite;
        req.addr = paddr;
        req.wdata = pwdata;
    end

    // decode, zero wait states
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign acc = req.sel && req.enable;
    assign wr = acc && req.write;
    assign rd = req.sel && !req.enable && !req.write;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // unmapped addresses read zero, writes ignored
    assign ctrlAcc = acc && hit(req.addr, `CCI_CMPCTRL_OFF);
    assign mismatch = (s2_q != ref_q);
    assign irqOn = chg_q && cmpIe_q && periph_irq_enable_q && gIe_q;

    // register words, one 32-bit word each, data in the low bits:
    //   control: live outputs at 7:6, comparator mode at 2:0
    //   flag two: change flag at 6, software loads it, a change sets it
    //   enable two: local comparator enable at 6
    //   interrupt control: global enable at 7, peripheral enable at 6
    //   converter one: port role field at 3:0, zero keeps pins analog
    //   vref control: whole byte, bit 6 drives the reference pin
    //   status: change at 0, wake at 1, a written one clears
    //   mask: same layout as status, a one masks the bit
    // every register answers in the first access cycle

    // hazards worth knowing:
    //   a change that meets a control access in one cycle is lost
    //   pins high at reset differ from the cleared copy and set the flag
    //   sleep gates no clock here, so all state keeps running asleep
    //   read data leaves a flop, built while the setup cycle stands
    //   writes land at the edge that ends the access cycle

    // write strobes, one per mapped register word
    logic wrCtrl; // control register write
    logic wrFlag; // flag register write
    logic wrEn; // local enable register write
    logic wrIrq; // interrupt control register write
    logic wrConv; // converter control register write
    logic wrVref; // vref control register write
    logic wrStat; // status register write, ones clear
    logic wrMask; // mask register write
    logic evtSet; // change event that sets flag and status
    logic wakeSet; // wake condition while asleep

    // decode each write once; unmapped offsets match none of them
    assign wrCtrl = wr && hit(req.addr, `CCI_CMPCTRL_OFF);
    assign wrFlag = wr && hit(req.addr, `CCI_FLAGREG2_OFF);
    assign wrEn = wr && hit(req.addr, `CCI_ENREG2_OFF);
    assign wrIrq = wr && hit(req.addr, `CCI_IRQCTRL_OFF);
    assign wrConv = wr && hit(req.addr, `CCI_CONV1_OFF);
    assign wrVref = wr && hit(req.addr, `CCI_VREFCTRL_OFF);
    assign wrStat = wr && hit(req.addr, `CCI_IRQSTAT_OFF);
    assign wrMask = wr && hit(req.addr, `CCI_IRQMASK_OFF);

    // a control access in the same cycle swallows the change
    assign evtSet = mismatch && !ctrlAcc;
    // waking needs the local enable only, not the global one
    assign wakeSet = sleepMode && chg_q && cmpIe_q;

    // synchroniser next values; the raw pins feed stage one only
    // stage one may go metastable, so no logic but stage two reads it
    always_comb begin
        s1_d = {cmp2Raw, cmp1Raw}; // asynchronous comparator pins
        s2_d = s1_q; // stage two is the only stage read
    end

    // synchroniser flops, cleared to the idle level of the pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    // reference copy follows the live outputs on any control access
    // the copy is what software last saw, give or take the sync delay
    always_comb begin
        ref_d = ref_q; // held between accesses
        if (ctrlAcc) begin
            ref_d = s2_q;
        end
    end

    // reference copy flop; cleared so pins high at reset raise a change
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_q <= 2'h0;
        end else begin
            ref_q <= ref_d;
        end
    end

    // change flag: software loads it, a live mismatch sets it again
    // the written bit is loaded as is, so a one simulates a change
    always_comb begin
        chg_d = chg_q; // hardware never clears it
        if (wrFlag) begin
            chg_d = req.wdata[`CCI_CHG_BIT];
        end
        // set beats a clear in the same cycle, asleep or awake
        // hazard: a change caught by a control access is lost, see evtSet
        if (evtSet) begin
            chg_d = 1'b1;
        end
    end

    // change flag flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chg_q <= 1'b0;
        end else begin
            chg_q <= chg_d;
        end
    end

    // local comparator enable, a plain read-write bit
    // the wake output needs only this enable
    always_comb begin
        cmpIe_d = cmpIe_q; // holds unless written
        if (wrEn) begin
            cmpIe_d = req.wdata[`CCI_CMPIE_BIT];
        end
    end

    // local enable flop, off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmpIe_q <= 1'b0;
        end else begin
            cmpIe_q <= cmpIe_d;
        end
    end

    // peripheral and global enables share one register word
    // both must be set, with the local enable, to raise the request
    always_comb begin
        periph_irq_enable_d = periph_irq_enable_q; // peripheral enable holds
        gIe_d = gIe_q; // global enable holds
        if (wrIrq) begin
            periph_irq_enable_d = req.wdata[`CCI_PERIPH_IRQ_ENABLE_BIT];
            gIe_d = req.wdata[`CCI_GIE_BIT];
        end
    end

    // peripheral and global enable flops, off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            periph_irq_enable_q <= 1'b0;
            gIe_q <= 1'b0;
        end else begin
            periph_irq_enable_q <= periph_irq_enable_d;
            gIe_q <= gIe_d;
        end
    end

    // comparator mode field; sleep and wake never touch it
    always_comb begin
        cfg_d = cfg_q; // holds unless written
        if (wrCtrl) begin
            cfg_d = req.wdata[`CCI_CFG_LSB +: 3]; // mode code
        end
    end

    // comparator mode flop, all comparators off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_q <= `CCI_CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // port roles and vref control; only bus writes move them
    always_comb begin
        pcfg_d = pcfg_q; // port roles hold
        vref_d = vref_q; // vref settings hold
        if (wrConv) begin
            pcfg_d = req.wdata[3:0];
        end
        if (wrVref) begin
            vref_d = req.wdata[7:0]; // whole control byte
        end
    end

    // port and vref flops; pins analog and vref off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pcfg_q <= `CCI_PCFG_RST;
            vref_q <= `CCI_VREF_RST;
        end else begin
            pcfg_q <= pcfg_d;
            vref_q <= vref_d;
        end
    end

    // sticky status: written ones clear, events set, set wins
    // the wake event uses the same condition as the wake output
    always_comb begin
        st_d = st_q; // sticky by default
        if (wrStat) begin
            st_d = st_q & ~req.wdata[1:0]; // write one to clear
        end
        if (evtSet) begin
            st_d.change = 1'b1; // comparator change event
        end
        if (wakeSet) begin
            st_d.wake = 1'b1; // wake event while asleep
        end
    end

    // status flops, nothing pending after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= 2'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // interrupt mask, same layout as status
    always_comb begin
        msk_d = msk_q; // holds unless written
        if (wrMask) begin
            msk_d = req.wdata[1:0]; // a one masks the bit
        end
    end

    // mask flops, every bit unmasked after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msk_q <= 2'h0;
        end else begin
            msk_q <= msk_d;
        end
    end

    // read data is built in the setup cycle so prdata leaves a flop
    // live outputs are those at setup, one cycle before the copy refresh
    always_comb begin
        rdata_d = rdata_q; // held through the access cycle
        if (rd) begin
            rdata_d = 32'h0; // unused bits read zero
            case (req.addr)
                `CCI_CMPCTRL_OFF: begin
                    rdata_d[`CCI_CMP2_OUTPUT_BIT] = s2_q[1];
                    rdata_d[`CCI_CMP1_OUTPUT_BIT] = s2_q[0];
                    rdata_d[`CCI_CFG_LSB +: 3] = cfg_q;
                end
                `CCI_FLAGREG2_OFF: begin
                    rdata_d[`CCI_CHG_BIT] = chg_q;
                end
                `CCI_ENREG2_OFF: begin
                    rdata_d[`CCI_CMPIE_BIT] = cmpIe_q;
                end
                `CCI_IRQCTRL_OFF: begin
                    rdata_d[`CCI_PERIPH_IRQ_ENABLE_BIT] = periph_irq_enable_q;
                    rdata_d[`CCI_GIE_BIT] = gIe_q;
                end
                `CCI_CONV1_OFF: begin
                    rdata_d[3:0] = pcfg_q;
                end
                `CCI_VREFCTRL_OFF: begin
                    rdata_d[7:0] = vref_q;
                end
                `CCI_IRQSTAT_OFF: begin
                    rdata_d[1:0] = st_q;
                end
                `CCI_IRQMASK_OFF: begin
                    rdata_d[1:0] = msk_q;
                end
                default: begin
                    rdata_d = 32'h0; // unmapped offsets read zero
                end
            endcase
        end
    end

    // read data flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs; data leave flops, interrupt lines are gates of flops
    // the interrupt lines settle within the cycle after their flops
    assign prdata = rdata_q; // read data from its flop
    assign cmpIrqReq = irqOn;
    assign wakeReq = wakeSet;
    assign cmpConfigField = cfg_q; // comparator mode field
    assign portAnalogConfig = pcfg_q; // port role field
    assign vrefControl = vref_q; // whole vref control byte
    assign vrefOutPinEn = vref_q[`CCI_VOE_BIT];
    // a set status bit whose mask bit is clear raises the line
    assign sysIrq = |(st_q & ~msk_q);
endmodule // comparator_change_irq

//--- verif/cci_cmp_model.sv
`timescale 1ns/1ps
// analog comparator pair: outputs settle shortly after the commanded level
module cci_cmp_model (
    input wire logic [1:0] level,
    output wire logic cmp1Raw,
    output wire logic cmp2Raw
);
    // asynchronous to the bus clock, like a real analog edge
    assign #1.3 {cmp2Raw, cmp1Raw} = level;
endmodule // cci_cmp_model

//--- verif/cci_sva.sv
`timescale 1ns/1ps
`include "cci_regs.svh"
module cci_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleepMode,
    input wire logic wakeReq,
    input wire logic [2:0] cmpConfigField,
    input wire logic [3:0] portAnalogConfig,
    input wire logic [7:0] vrefControl,
    input wire logic vrefOutPinEn
);
    // one clock domain for every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic wrAcc; // write in access phase
    assign wrAcc = psel && penable && pwrite;
    a_zero_wait: assert property (psel && penable |-> pready) else $error("no ready");
    a_no_error: assert property (!pslverr) else $error("slave error raised");
    a_pin_drive: assert property (vrefOutPinEn == vrefControl[6])
        else $error("pin drive differs from enable");
    a_wake_sleep: assert property (wakeReq |-> sleepMode) else $error("wake while awake");
    a_cfg_write: assert property (wrAcc && paddr == `CCI_CMPCTRL_OFF
        |=> cmpConfigField == 3'($past(pwdata))) else $error("config write lost");
    a_port_write: assert property (wrAcc && paddr == `CCI_CONV1_OFF
        |=> portAnalogConfig == 4'($past(pwdata))) else $error("port write lost");
    a_vref_write: assert property (wrAcc && paddr == `CCI_VREFCTRL_OFF
        |=> vrefControl == 8'($past(pwdata))) else $error("vref write lost");
    a_sleep_cfg: assert property (sleepMode && !wrAcc |=> $stable(cmpConfigField))
        else $error("config moved in sleep");
    a_sleep_vref: assert property (sleepMode && !wrAcc |=> $stable(vrefControl))
        else $error("vref moved in sleep");
endmodule // cci_sva
bind comparator_change_irq cci_sva u_sva (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .sleepMode, .wakeReq, .cmpConfigField, .portAnalogConfig,
    .vrefControl, .vrefOutPinEn);

//--- verif/test_comparator_change_irq.sv
`timescale 1ns/1ps
`include "cci_regs.svh"
module test_comparator_change_irq;
    logic clock = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic sleepMode = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [1:0] level = 0; // commanded comparator levels
    logic [31:0] prdata, q;
    logic pready, pslverr, cmp1Raw, cmp2Raw, cmpIrqReq, wakeReq, vrefOutPinEn, sysIrq;
    logic [2:0] cmpConfigField;
    logic [3:0] portAnalogConfig;
    logic [7:0] vrefControl;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    comparator_change_irq dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmp1Raw, .cmp2Raw, .sleepMode, .cmpIrqReq, .wakeReq,
        .cmpConfigField, .portAnalogConfig, .vrefControl, .vrefOutPinEn, .sysIrq);
    cci_cmp_model u_cmp (.level, .cmp1Raw, .cmp2Raw);
    // free running bus clock
    initial forever #2 clock = ~clock;
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    task final_report();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // one apb transfer, held until ready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task rx(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    // move the comparators, then let the sync chain settle
    task lv(input logic [1:0] v, input logic s);
        @(posedge clock);
        level <= v;
        sleepMode <= s;
        repeat (8) @(posedge clock);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 0;
        rx(`CCI_CMPCTRL_OFF, 32'h7);
        rx(`CCI_CONV1_OFF, 32'h0);
        rx(`CCI_VREFCTRL_OFF, 32'h0);
        lv(2'h1, 0);
        rx(`CCI_FLAGREG2_OFF, 32'h40);
        chk("irq", 32'(cmpIrqReq), 32'h0);
        chk("sys", 32'(sysIrq), 32'h1);
        rx(`CCI_CMPCTRL_OFF, 32'h47);
        apb(1, `CCI_FLAGREG2_OFF, 32'h0);
        rx(`CCI_FLAGREG2_OFF, 32'h0);
        lv(2'h3, 0);
        apb(1, `CCI_FLAGREG2_OFF, 32'h0);
        rx(`CCI_FLAGREG2_OFF, 32'h40);
        rx(`CCI_CMPCTRL_OFF, 32'hC7);
        apb(1, `CCI_FLAGREG2_OFF, 32'h0);
        rx(`CCI_FLAGREG2_OFF, 32'h0);
        apb(1, `CCI_IRQMASK_OFF, 32'h3);
        chk("sys", 32'(sysIrq), 32'h0);
        apb(1, `CCI_IRQMASK_OFF, 32'h0);
        apb(1, `CCI_IRQSTAT_OFF, 32'h3);
        chk("sys", 32'(sysIrq), 32'h0);
        apb(1, `CCI_FLAGREG2_OFF, 32'h40);
        rx(`CCI_FLAGREG2_OFF, 32'h40);
        apb(1, `CCI_ENREG2_OFF, 32'h40);
        apb(1, `CCI_IRQCTRL_OFF, 32'h80);
        chk("irq", 32'(cmpIrqReq), 32'h0);
        apb(1, `CCI_IRQCTRL_OFF, 32'hC0);
        chk("irq", 32'(cmpIrqReq), 32'h1);
        apb(1, `CCI_FLAGREG2_OFF, 32'h0);
        apb(1, `CCI_CMPCTRL_OFF, 32'h2);
        apb(1, `CCI_VREFCTRL_OFF, 32'hC5);
        chk("pin", 32'(vrefOutPinEn), 32'h1);
        lv(2'h2, 1);
        chk("wake", 32'(wakeReq), 32'h1);
        lv(2'h2, 0);
        rx(`CCI_CMPCTRL_OFF, 32'h82);
        rx(`CCI_VREFCTRL_OFF, 32'hC5);
        apb(1, `CCI_VREFCTRL_OFF, 32'h5);
        chk("pin", 32'(vrefOutPinEn), 32'h0);
        apb(1, 12'h020, 32'hFF);
        rx(12'h020, 32'h0);
        // second reset in mid-run, pins still high on comparator two
        @(posedge clock);
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        repeat (4) @(posedge clock);
        rx(`CCI_FLAGREG2_OFF, 32'h40);
        rx(`CCI_CMPCTRL_OFF, 32'h87);
        rx(`CCI_VREFCTRL_OFF, 32'h0);
        final_report();
    end
endmodule // test_comparator_change_irq
